// File: core/aods_pkg.sv
// Constants and types for the converter output steering block
// Operation
// - Dual mode alternates results between ports
// - In dual mode each port updates at half strobe rate
// - Internal divide-by-two drives port alternation
// - Sync fall or high pulse realigns divider
// - Conflicting sync drops one sample: port A takes two words in a row
// - Matching sync leaves output data untouched
// - Dual mode latency is six strobe cycles
// - Single mode: every result on port A
// - One sample on every rising strobe edge
// - Single mode latency is five strobe cycles
// - Single mode holds port B static
package aods_pkg;
	localparam int           AODS_WIDTH      = 8;
	localparam int           AODS_LAT_SINGLE = 4;
	localparam int           AODS_LAT_DUAL   = 5;
	localparam logic [7:0]   AODS_RST_DATA   = 8'h00;
	localparam logic         AODS_RST_PHASE  = 1'b0;
	localparam logic [2:0]   AODS_RST_SYNC   = 3'h0;
	localparam logic [1:0]   AODS_RST_MODE   = 2'h0;

	typedef logic [AODS_WIDTH-1:0] aods_word_t;

	typedef struct packed
	{
		aods_word_t port_a;
		aods_word_t port_b;
	} aods_ports_s;
endpackage

// File: core/aods_adc_output_port_split_select_n_sync.sv
// Output steering and phase sync for an 8-bit sampling converter
`timescale 1ns/100ps
module aods_adc_output_port_split_select_n_sync
	import aods_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire aods_pkg::aods_word_t sample_in,
	input  wire logic                 port_split_select_n,
	input  wire logic                 sample_phase_sync,
	output aods_pkg::aods_ports_s     ports_out,
	output logic                      phase_r
);
	import aods_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// True when the divider phase hands the next dual word to port A
	function automatic logic phase_selects_a
	(
		input logic phase
	);
		return (phase == AODS_RST_PHASE);
	endfunction

	// True when port B takes a new word on this strobe
	function automatic logic port_b_due
	(
		input logic single,
		input logic phase
	);
		return (~single & ~phase_selects_a(phase));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Pin synchroniser stages
	logic [2:0]  sync_sh_r;
	logic [1:0]  mode_sh_r;

	// Decoded pin events
	logic        sync_fall;
	logic        single_mode;

	// Divider
	logic        phase_nxt;

	// Sample pipeline, one word per strobe
	aods_word_t  pipe_r [AODS_LAT_DUAL];

	// Port registers
	aods_word_t  port_a_r;
	aods_word_t  port_a_nxt;
	aods_word_t  port_b_r;
	aods_word_t  port_b_nxt;

	////////////////////////////////////////////////////////////////////////
	// Sync pin: two synchroniser stages, then one more for the edge

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync_sh_r <= AODS_RST_SYNC;
		end
		else
		begin
			sync_sh_r <= {sync_sh_r[1:0], sample_phase_sync};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode pin: two synchroniser stages

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_sh_r <= AODS_RST_MODE;
		end
		else
		begin
			mode_sh_r <= {mode_sh_r[0], port_split_select_n};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded pin events

	// High selects single port mode
	assign single_mode = mode_sh_r[1];

	// End of a positive pulse is a falling edge too
	assign sync_fall   = sync_sh_r[2] & ~sync_sh_r[1];

	////////////////////////////////////////////////////////////////////////
	// Sample pipeline

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < AODS_LAT_DUAL; i++)
			begin
				pipe_r[i] <= AODS_RST_DATA;
			end
		end
		else
		begin
			pipe_r[0] <= sample_in;
			for (int i = 1; i < AODS_LAT_DUAL; i++)
			begin
				pipe_r[i] <= pipe_r[i-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port divider; phase 0 means next dual word goes to port A

	always_comb
	begin
		phase_nxt = ~phase_r;
		if (sync_fall)
		begin
			// Matching phase is left as it was, a conflict drops one word
			phase_nxt = AODS_RST_PHASE;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase_r <= AODS_RST_PHASE;
		end
		else
		begin
			phase_r <= phase_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port A

	always_comb
	begin
		port_a_nxt = port_a_r;
		if (single_mode)
		begin
			port_a_nxt = pipe_r[AODS_LAT_SINGLE-1];
		end
		else if (phase_selects_a(phase_r))
		begin
			port_a_nxt = pipe_r[AODS_LAT_DUAL-1];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			port_a_r <= AODS_RST_DATA;
		end
		else
		begin
			port_a_r <= port_a_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port B

	always_comb
	begin
		// Holds its last word in single port mode
		port_b_nxt = port_b_r;
		if (port_b_due(single_mode, phase_r))
		begin
			port_b_nxt = pipe_r[AODS_LAT_DUAL-1];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			port_b_r <= AODS_RST_DATA;
		end
		else
		begin
			port_b_r <= port_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output assembly, straight from the port registers

	assign ports_out = '{port_a: port_a_r, port_b: port_b_r};

endmodule

// File: testbench/aods_chk_assertions.sv
// Port timing checks for the output steering block
`timescale 1ns/100ps
module aods_chk
	import aods_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire aods_pkg::aods_word_t sample_in,
	input wire logic port_split_select_n,
	input wire logic sample_phase_sync,
	input wire aods_pkg::aods_ports_s ports_out,
	input wire logic phase_r
);
	logic [6:0] d_r, y_r;
	logic [3:0] run_r;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			run_r <= 4'h0;
		else if (run_r != 4'hF)
			run_r <= run_r + 4'h1;
	end
	wire warm = run_r > 4'h8;
	wire aods_word_t a = ports_out.port_a, b = ports_out.port_b;
	wire y = sample_phase_sync;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk)
	begin
		d_r <= {d_r[5:0], !port_split_select_n};
		y_r <= {y_r[5:0], y};
	end
	chk_single_lat: assert property (warm && ~|d_r |-> a == $past(sample_in, 5))
		else $error("a");
	chk_b_static: assert property (warm && ~|d_r |-> $stable(b)) else $error("b");
	chk_dual_a: assert property (warm && &d_r && !$past(phase_r)
		|-> a == $past(sample_in, 6) && $stable(b)) else $error("da");
	chk_dual_b: assert property (warm && &d_r && $past(phase_r)
		|-> b == $past(sample_in, 6) && $stable(a)) else $error("db");
	chk_phase_tog: assert property (warm && ~|y_r && !y
		|-> phase_r != $past(phase_r)) else $error("tog");
	chk_sync_fall: assert property (warm && $fell(y) |-> ##3 !phase_r) else $error("sy");
	chk_phase_stay: assert property (warm |-> phase_r != $past(phase_r) || !phase_r)
		else $error("st");
	chk_sync_match: assert property (warm && $fell(y) ##2 phase_r |=> !phase_r)
		else $error("mt");
endmodule
bind aods_adc_output_port_split_select_n_sync aods_chk u_chk (.*);

// File: testbench/aods_cap.sv
// Capture register pairing both ports into one word
`timescale 1ns/100ps
module aods_cap
	import aods_pkg::*;
(
	input wire logic clk,
	input wire aods_pkg::aods_ports_s ports_out,
	input wire logic phase_r,
	output logic [15:0] word_r
);
	always_ff @(posedge clk)
	begin
		if (!phase_r)
			word_r <= ports_out;
	end
endmodule

// File: testbench/aods_adc_output_port_split_select_n_sync_tb.sv
// Bench for the output steering block
`timescale 1ns/100ps
module aods_adc_output_port_split_select_n_sync_tb;
	import aods_pkg::*;
	logic clk = 0, resetn = 0, m = 1, y = 0, ph;
	aods_word_t s = 8'h00;
	aods_ports_s p;
	logic [15:0] w;
	int err_count = 0, num_checks = 0, cyc = 0;
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		if (resetn)
			s <= s + 8'h01;
		if (++cyc > 600)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	aods_adc_output_port_split_select_n_sync dut (.clk(clk), .resetn(resetn), .sample_in(s),
		.port_split_select_n(m), .sample_phase_sync(y), .ports_out(p), .phase_r(ph));
	aods_cap cap (.clk(clk), .ports_out(p), .phase_r(ph), .word_r(w));
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (e !== g)
		begin
			$display("wrong value %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask
	task cmp_bit(input string n, input logic e, input logic g);
		num_checks++;
		if (e !== g)
		begin
			$display("wrong value %s exp %b got %b", n, e, g);
			err_count++;
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task single;
		aods_word_t hold_b;
		repeat (6) @(posedge clk);
		@(negedge clk);
		hold_b = p.port_b;
		repeat (10)
		begin
			@(negedge clk);
			cmp("a", s - 8'h05, p.port_a);
			cmp("b", hold_b, p.port_b);
		end
	endtask
	task dual;
		@(posedge clk) m <= 0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk) y <= (i == 0) || (i >= 20 && i % 2 == 0);
			@(negedge clk);
			if (i == 4)
				cmp_bit("phase sync", 1'b0, ph);
			if (i == 5)
				cmp_bit("phase toggle", 1'b1, ph);
			if (i > 12)
				cmp("word", w[15:8] + 8'h01, w[7:0]);
		end
	endtask
	task conflict;
		@(negedge clk);
		while (ph !== 1'b0)
			@(negedge clk);
		@(posedge clk) y <= 1'b1;
		@(posedge clk) y <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmp_bit("phase forced", 1'b0, ph);
		@(negedge clk);
		cmp_bit("phase after", 1'b1, ph);
		repeat (12) @(negedge clk);
		repeat (10)
		begin
			@(negedge clk);
			cmp("word resync", w[15:8] + 8'h01, w[7:0]);
		end
	endtask
	task mid_reset;
		@(posedge clk) resetn <= 1'b0;
		@(negedge clk);
		cmp("a rst", AODS_RST_DATA, p.port_a);
		cmp("b rst", AODS_RST_DATA, p.port_b);
		cmp_bit("phase rst", AODS_RST_PHASE, ph);
		repeat (9) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		cmp_bit("phase run", ~AODS_RST_PHASE, ph);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1;
		single();
		dual();
		conflict();
		mid_reset();
		dual();
		tally_and_finish();
	end
endmodule
